// file: design/fan_tach_monitor.sv
// fan tachometer monitor with config-mode discovery and indexed ports
// assumes io_* strobes and tach_in synchronous to ref_clk, one cycle each
// limitation: a glitch on tach_in counts as an edge
//
// What this block does
// - sixteen-bit count readable as two bytes
// - reading one byte freezes the other byte
// - stalled fan reports all ones
// - count reference ticks across five tach edges
// - control bit 0 at index 0x40 starts
// - low byte index 0x28, high 0x29
// - index port base+0x70, data port next
// - 0x2E config index, 0x55 enter, 0xAA exit
// - device 0x0A selects base at 0x60/0x61
`timescale 1ns/10ps
`default_nettype none
module fan_tach_monitor #(
  parameter logic [15:0] RUNTIME_BASE = 16'h0A00, // arbitrary default
  parameter int REF_DIVIDE = fan_tach_pkg::REF_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic tach_in,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  output logic monitor_running
);
  import fan_tach_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset asserts at once, releases two edges later
  // so every flop leaves reset on the same edge
  logic [1:0] rst_sync_r;
  logic rst_ok;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_ok = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // port decode
  // the runtime ports follow the base; other addresses fall through
  logic [15:0] mon_index_port;
  logic [15:0] mon_data_port;
  logic cfg_mode_r;
  logic [7:0] cfg_index_r;
  logic [7:0] dev_sel_r;
  logic [7:0] rt_index_r;
  logic [7:0] run_ctrl_r;
  assign mon_index_port = RUNTIME_BASE + MONITOR_PORT_OFFSET;
  assign mon_data_port = mon_index_port + 16'h0001;

  wire cfg_idx_wr = io_wr && (io_addr == CONFIG_INDEX_PORT);
  wire cfg_dat_wr = io_wr && cfg_mode_r && (io_addr == CONFIG_DATA_PORT);
  wire cfg_dat_rd = io_rd && (io_addr == CONFIG_DATA_PORT);
  wire rt_idx_wr = io_wr && (io_addr == mon_index_port);
  wire rt_dat_wr = io_wr && (io_addr == mon_data_port);
  wire rt_dat_rd = io_rd && (io_addr == mon_data_port);
  wire rd_low = rt_dat_rd && (rt_index_r == TACH_COUNT_INDEX);
  wire rd_high = rt_dat_rd && (rt_index_r == TACH_COUNT_HIGH_INDEX);
  wire rt_dev = (dev_sel_r == RUNTIME_DEVICE);
  // key bytes never land in the index latch
  wire cfg_enter = cfg_idx_wr && (io_wdata == CONFIG_ENTER);
  wire cfg_exit = cfg_idx_wr && (io_wdata == CONFIG_EXIT);
  wire cfg_sel_wr = cfg_idx_wr && cfg_mode_r;
  wire dev_sel_wr = cfg_dat_wr && (cfg_index_r == DEV_SELECT_INDEX);
  // whole byte kept so a read-modify-write saves the other bits
  wire run_ctrl_wr = rt_dat_wr && (rt_index_r == RUN_CONTROL_INDEX);

  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      cfg_mode_r <= 1'b0;
      cfg_index_r <= 8'h00;
      dev_sel_r <= 8'h00;
    end else begin
      if (cfg_enter) cfg_mode_r <= 1'b1;
      else if (cfg_exit) cfg_mode_r <= 1'b0;
      else if (cfg_sel_wr) cfg_index_r <= io_wdata;
      if (dev_sel_wr) begin
        dev_sel_r <= io_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      rt_index_r <= 8'h00;
      run_ctrl_r <= RUN_CONTROL_RESET;
    end else begin
      if (rt_idx_wr) rt_index_r <= io_wdata;
      if (run_ctrl_wr) begin
        run_ctrl_r <= io_wdata;
      end
    end
  end
  wire run_en = run_ctrl_r[START_BIT];

  ////////////////////////////////////////////////////////////////////////
  // 90 kHz reference tick
  // an enable pulse, not a second clock domain
  logic [15:0] div_r;
  wire ref_tick = (div_r == 16'(REF_DIVIDE - 1));
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) div_r <= 16'h0000;
    else if (ref_tick) div_r <= 16'h0000;
    else div_r <= div_r + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // period measurement; edges counted on both tach transitions
  logic tach_d_r;
  logic [2:0] edges_r;
  logic [15:0] period_r;
  logic [15:0] result_r;
  wire tach_edge = tach_in ^ tach_d_r;
  wire period_full = (period_r == TACH_STALLED);
  wire window_done = tach_edge && (edges_r == TACH_EDGES - 3'h1);
  // the tick of the closing cycle belongs to the window it ends
  wire [15:0] period_closed = (ref_tick && !period_full) ?
    period_r + 16'h0001 : period_r;
  // clearing the start bit keeps the last result readable

  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      tach_d_r <= 1'b0;
      edges_r <= 3'h0;
      period_r <= 16'h0000;
      result_r <= TACH_STALLED;
    end else begin
      tach_d_r <= tach_in;
      if (!run_en) begin
        edges_r <= 3'h0;
        period_r <= 16'h0000;
      end else if (window_done) begin
        result_r <= period_closed;
        edges_r <= 3'h1; // closing edge opens next window
        period_r <= 16'h0000;
      end else if (period_full) begin
        result_r <= TACH_STALLED;
        edges_r <= 3'h0;
        period_r <= 16'h0000;
      end else begin
        if (tach_edge) edges_r <= edges_r + 3'h1;
        if (ref_tick && edges_r != 3'h0) begin
          period_r <= period_r + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte latching: reading one half freezes the other
  // either order pairs; the host takes low then high
  logic [7:0] low_hold_r;
  logic [7:0] high_hold_r;
  logic low_locked_r;
  logic high_locked_r;
  wire [7:0] low_view = low_locked_r ? low_hold_r : result_r[7:0];
  wire [7:0] high_view = high_locked_r ? high_hold_r : result_r[15:8];

  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      low_hold_r <= 8'h00;
      high_hold_r <= 8'h00;
      low_locked_r <= 1'b0;
      high_locked_r <= 1'b0;
    end else if (rd_low) begin
      low_locked_r <= 1'b0;
      high_locked_r <= !low_locked_r;
      high_hold_r <= result_r[15:8];
    end else if (rd_high) begin
      high_locked_r <= 1'b0;
      low_locked_r <= !high_locked_r;
      low_hold_r <= result_r[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data mux
  // unmapped addresses float high like an idle bus; unknown runtime indexes read 0x00
  wire [7:0] base_high_view = rt_dev ? RUNTIME_BASE[15:8] : IDLE_READ;
  wire [7:0] base_low_view = rt_dev ? RUNTIME_BASE[7:0] : IDLE_READ;
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = IDLE_READ;
    if (cfg_dat_rd && cfg_mode_r) begin
      case (cfg_index_r)
        DEV_SELECT_INDEX: rd_mux = dev_sel_r;
        BASE_HIGH_INDEX: rd_mux = base_high_view;
        BASE_LOW_INDEX: rd_mux = base_low_view;
        default: rd_mux = IDLE_READ;
      endcase
    end else if (rt_dat_rd) begin
      case (rt_index_r)
        TACH_COUNT_INDEX: rd_mux = low_view;
        TACH_COUNT_HIGH_INDEX: rd_mux = high_view;
        RUN_CONTROL_INDEX: rd_mux = run_ctrl_r;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
      monitor_running <= 1'b0;
    end else begin
      // answer one cycle after the strobe, data held until next read
      io_rvalid <= io_rd;
      if (io_rd) io_rdata <= rd_mux;
      monitor_running <= run_en;
    end
  end
endmodule : fan_tach_monitor
`default_nettype wire

// file: design/fan_tach_pkg.sv
// constants for the fan tachometer monitor
// assumes one 250 MHz clock and a host byte-wide I/O port bus
package fan_tach_pkg;
  localparam int CLK_HZ = 250000000;
  localparam int REF_HZ = 90000;
  localparam int REF_DIV = CLK_HZ / REF_HZ;
  localparam logic [15:0] CONFIG_INDEX_PORT = 16'h002E;
  localparam logic [15:0] CONFIG_DATA_PORT = 16'h002F;
  localparam logic [7:0] CONFIG_ENTER = 8'h55;
  localparam logic [7:0] CONFIG_EXIT = 8'hAA;
  localparam logic [7:0] DEV_SELECT_INDEX = 8'h07;
  localparam logic [7:0] RUNTIME_DEVICE = 8'h0A;
  localparam logic [7:0] BASE_HIGH_INDEX = 8'h60;
  localparam logic [7:0] BASE_LOW_INDEX = 8'h61;
  localparam logic [15:0] MONITOR_PORT_OFFSET = 16'h0070;
  localparam logic [7:0] TACH_COUNT_INDEX = 8'h28;
  localparam logic [7:0] TACH_COUNT_HIGH_INDEX = 8'h29;
  localparam logic [7:0] RUN_CONTROL_INDEX = 8'h40;
  localparam int START_BIT = 0;
  localparam logic [7:0] RUN_CONTROL_RESET = 8'h00;
  localparam logic [15:0] TACH_STALLED = 16'hFFFF;
  localparam logic [2:0] TACH_EDGES = 3'h5;
  localparam logic [7:0] IDLE_READ = 8'hFF;
endpackage : fan_tach_pkg

// file: verification/host.sv
// host partner on the byte-wide port bus
// assumes ref_clk from the bench
`timescale 1ns/10ps
`default_nettype none
module host (
  input wire logic ref_clk,
  input wire logic [7:0] io_rdata,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  initial {io_addr, io_wr, io_rd, io_wdata} = '0;
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {io_addr, io_wdata, io_wr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    {io_wr, io_wdata} <= {1'b0, ~d}; // stale data not left showing
  endtask : wr
  task rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    {io_addr, io_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    io_rd <= 1'b0;
    @(posedge ref_clk);
    d = io_rdata;
  endtask : rd
  task ird(input logic [15:0] p, input logic [7:0] i, output logic [7:0] d);
    wr(p, i);
    rd(p + 16'h0001, d);
  endtask : ird
endmodule : host
`default_nettype wire

// file: verification/fan_tach_monitor_props.sv
// port-level checks on the monitor
// assumes bind into fan_tach_monitor, one clock
`timescale 1ns/10ps
`default_nettype none
module fan_tach_monitor_props #(
  parameter logic [15:0] RUNTIME_BASE = 16'h0000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_rvalid,
  input wire logic monitor_running,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] idx_r;
  wire dport = io_addr == RUNTIME_BASE + 16'h0071;
  wire run_wr = io_wr && dport && idx_r == 8'h40;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) idx_r <= 8'h00;
    else if (io_wr && io_addr == RUNTIME_BASE + 16'h0070) idx_r <= io_wdata;
  end
  property p_ans; io_rd |=> io_rvalid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !io_rd |=> !io_rvalid; endproperty
  a_one: assert property (p_one) else $error("extra answer");
  property p_hold; !io_rvalid |-> $stable(io_rdata); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_miss; io_rd && io_addr == 16'h0080 |=> io_rdata == 8'hFF;
  endproperty
  a_miss: assert property (p_miss) else $error("unmapped read");
  property p_unk; io_rd && dport && idx_r == 8'h30 |=> io_rdata == 8'h00;
  endproperty
  a_unk: assert property (p_unk) else $error("unknown index");
  property p_go; run_wr && io_wdata[0] |-> ##[1:2] monitor_running;
  endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_halt; run_wr && !io_wdata[0] |-> ##[1:2] !monitor_running;
  endproperty
  a_halt: assert property (p_halt) else $error("no stop");
  property p_why; $changed(monitor_running) |-> $past(io_wr) || $past(io_wr, 2);
  endproperty
  a_why: assert property (p_why) else $error("run flag moved");
endmodule : fan_tach_monitor_props
bind fan_tach_monitor fan_tach_monitor_props #(.RUNTIME_BASE(RUNTIME_BASE))
  u_props (.ref_clk(ref_clk), .rst_n(rst_n), .io_wr(io_wr), .io_rd(io_rd),
  .io_rvalid(io_rvalid), .monitor_running(monitor_running),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));
`default_nettype wire

// file: verification/tb_fan_tach_monitor.sv
// self-checking bench for the fan tach monitor
// assumes REF_DIVIDE of 1 so a stall saturates within the run
`timescale 1ns/10ps
`default_nettype none
module tb_fan_tach_monitor;
  localparam logic [15:0] BASE = 16'h0C40;
  localparam logic [15:0] IX = BASE + 16'h0070;
  logic ref_clk = 1'b0, rst_n = 1'b0, tach_in = 1'b0;
  logic io_wr, io_rd, io_rvalid, run;
  logic [15:0] io_addr, c;
  logic [7:0] io_wdata, io_rdata, b;
  int err_count = 0, total_checks = 0, half = 0, cnt = 0, p;
  int seed = 32'hd6a2c6a5;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cnt <= (half == 0 || cnt >= half - 1) ? 0 : cnt + 1;
    if (half != 0 && cnt >= half - 1) tach_in <= ~tach_in;
  end
  host u_host (.ref_clk(ref_clk), .io_rdata(io_rdata), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
  fan_tach_monitor #(.RUNTIME_BASE(BASE), .REF_DIVIDE(1))
    u_fan_tach_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .tach_in(tach_in),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .monitor_running(run));
  task chk(input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) err_count++;
    if (seen !== exp) $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
  endtask : chk
  // four edge intervals at one tick a clock; no rotation reads all ones
  function automatic logic [15:0] exp_count(input int h);
    if (h == 0 || 4 * h > 65535) return 16'hFFFF;
    return 16'(4 * h);
  endfunction : exp_count
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task rck(input logic [15:0] a, input logic [7:0] i, e);
    u_host.ird(a, i, b);
    chk(b, e);
  endtask : rck
  // low byte, optional speed change and wait, then high byte
  task pck(input logic [15:0] e, input int tol, nh, gap);
    u_host.ird(IX, 8'h28, c[7:0]);
    half <= nh;
    repeat (gap) @(posedge ref_clk);
    u_host.ird(IX, 8'h29, c[15:8]);
    if (c + tol >= e && c <= e + tol) c = e;
    chk(c, e);
  endtask : pck
  task run_set(input logic on);
    u_host.ird(IX, 8'h40, b);
    u_host.wr(IX + 16'h0001, {b[7:1], on});
    repeat (3) @(posedge ref_clk);
    chk(run, on);
  endtask : run_set
  initial begin
    repeat (90000) @(posedge ref_clk);
    $display("[FAIL] %0t watchdog expired", $time);
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    u_host.wr(16'h002E, 8'h55);
    u_host.wr(16'h002E, 8'h07);
    u_host.wr(16'h002F, 8'h0A);
    rck(16'h002E, 8'h60, BASE[15:8]);
    rck(16'h002E, 8'h61, BASE[7:0]);
    u_host.wr(16'h002E, 8'hAA);
    rck(16'h002E, 8'h60, 8'hFF);
    rck(16'h007F, 8'h00, 8'hFF);
    rck(IX, 8'h30, 8'h00);
    pck(exp_count(0), 0, 0, 0);
    run_set(1'b1);
    $display("test setup done");
    p = 100 + {$random(seed)} % 150;
    half <= p;
    repeat (12 * p) @(posedge ref_clk);
    // speed change between the two byte reads tests the latch
    pck(exp_count(p), 0, p + 120, 12 * p + 1440);
    pck(exp_count(p + 120), 0, 0, 0);
    repeat (67000) @(posedge ref_clk);
    pck(exp_count(0), 0, 0, 0);
    run_set(1'b0);
    $display("test run done");
    print_verdict;
  end
endmodule : tb_fan_tach_monitor
`default_nettype wire
